// ### ssp_pkg.sv
// shared constants, word layouts and state codes of the serial program port
package ssp_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int LINK_BIT_NS   = 100;
   // half a bit period on the link, rounded up so the bit rate never exceeds the limit
   localparam int HALF_BIT_CYC  = (LINK_BIT_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
   localparam int SR_W          = 32;
   localparam int SHORT_LEN     = 24;
   localparam int LONG_LEN      = 32;
   localparam int SYNC_W        = 5;

   localparam logic [3:0] PFX_B = 4'h8;
   localparam logic [3:0] PFX_C = 4'h9;
   localparam logic [3:0] PFX_D = 4'ha;

   // moduli count read as {second bit, first bit}
   localparam logic [1:0] MOD_TWO   = 2'h0;
   localparam logic [1:0] MOD_THREE = 2'h1;
   localparam logic [1:0] MOD_FOUR  = 2'h2;

   localparam logic [3:0] FRAC_Q5 = 4'h5;
   localparam logic [3:0] FRAC_Q8 = 4'h8;

   // host register map, byte addresses
   localparam logic [11:0] REG_CTRL   = 12'h000;
   localparam logic [11:0] REG_DATA   = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam int CTRL_GO       = 0;
   localparam int CTRL_LONG     = 1;
   localparam int CTRL_HOLD_LSB = 16;
   localparam int STAT_BUSY     = 0;
   localparam int STAT_CNT_LSB  = 8;

   typedef struct packed {
      logic        zero;
      logic [2:0]  frac_increment;
      logic [11:0] first_ratio_cycles;
      logic [7:0]  ratio_counts;
   } ssp_word_a_t;

   typedef struct packed {
      ssp_word_a_t base;
      logic [7:0]  current_scale;
   } ssp_main_freq_long_word_t;

   typedef struct packed {
      logic [3:0] prefix;
      logic [3:0] cum_234;
      logic [7:0] current_scale;
      logic [3:0] integ_accel;
      logic [1:0] prop_exp;
      logic       moduli_p1;
      logic       moduli_p2;
   } ssp_word_b_t;

   typedef struct packed {
      logic [3:0]  prefix;
      logic [11:0] aux_divide;
      logic [7:0]  unused;
   } ssp_word_c_t;

   typedef struct packed {
      logic [3:0]  prefix;
      logic [11:0] ref_div_value;
      logic [1:0]  main_ref_sel;
      logic        main_off;
      logic [1:0]  aux_ref_sel;
      logic        aux_off;
      logic        frac_mod_sel;
      logic        long_sel;
   } ssp_word_d_t;

   typedef enum logic [1:0] {
      PH_R1 = 2'h0,
      PH_R2 = 2'h1,
      PH_R3 = 2'h3,
      PH_R4 = 2'h2
   } ssp_phase_t;

   typedef enum logic [1:0] {
      H_IDLE = 2'h0,
      H_LOW  = 2'h1,
      H_HIGH = 2'h3,
      H_STB  = 2'h2
   } ssp_host_st_t;
endpackage

// ### ssp_link_if.sv
// three-wire programming link between host and device
`timescale 1ns/1ps
interface ssp_link_if;
   logic sdata;
   logic sclk;
   logic strobe;
   modport host (output sdata, output sclk, output strobe);
   modport dev  (input sdata, input sclk, input strobe);
endinterface

// ### ssp_sync.sv
// two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module ssp_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } ssp_sync_st_t;

   ssp_sync_st_t r;
   ssp_sync_st_t next_r;

   if (WIDTH < 1) begin : g_chk
      $error("ssp_sync: WIDTH must be at least 1");
   end

   always_comb begin
      next_r = r;
      if (ce) begin
         next_r.s1 = d;
         next_r.s2 = r.s1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q = r.s2;
endmodule

// ### ssp_device.sv
// device end: serial word capture, decode, working registers and pump pulse control
//
// Contract
// - three-wire link, up to 10 Mbit/s
// - first setup sends A, B, C, D; the bench's first setup sends D, C, B, A
// - retune with B then A, or A
// - scale change uses long main_freq_long_word
// - capture on rising clock, word LSB first
// - strobe rise copies shift register out
// - word B parked until A or A2
// - speed-up while strobe high, clock ignored; here only a strobe that loads word A starts speed-up
// - word A layout zero, NF, N1, ratios
// - ratio nibbles: second, cumulative modulo 16
// - word B layout with prefix 1000
// - moduli select 00 two, 01 three, 10 four
// - word C aux divide, low byte ignored
// - sequence two, three or four moduli
// - cancel pulse sources accumulator value steps
// - cancel pulse two reference periods, straddling
// - cancel level scaled in speed-up mode
// - integral cancel pulse only in speed-up
// - word D layout with prefix 1010
// - long select picks A or A2
// - modulus select: 0 is 5, 1 is 8
// - disable bit switches synthesiser off
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module ssp_device
   import ssp_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                reset_n,
   input  wire logic                ce,
   ssp_link_if.dev                  link,
   input  wire logic                ref_in,
   input  wire logic                pre_pulse,
   output ssp_pkg::ssp_phase_t      ratio_sel,
   output logic                     frac_extra,
   output logic                     comp_pulse,
   output logic               [2:0] comp_level,
   output logic               [2:0] comp_shift,
   output logic               [7:0] prop_level,
   output logic               [2:0] prop_shift,
   output logic                     speedup,
   output logic                     integ_active,
   output logic                     integ_cancel_pulse,
   output logic               [3:0] integ_accel,
   output logic               [1:0] prescaler_moduli_sel,
   output logic              [11:0] aux_divide,
   output logic              [11:0] ref_div_value,
   output logic               [1:0] main_ref_sel,
   output logic               [1:0] aux_ref_sel,
   output logic                     main_off,
   output logic                     aux_off,
   output logic                     frac_mod_sel,
   output logic                     long_sel
);
   import ssp_pkg::*;

   typedef struct packed {
      logic [SR_W-1:0] sr;
      logic            sclk_q;
      logic            stb_q;
      logic            ref_q;
      logic            pre_q;
      logic            speedup;
      ssp_word_b_t     hold_b;
      ssp_word_b_t     work_b;
      ssp_word_d_t     cfg;
      logic [11:0]     aux_div;
      logic [2:0]      frac_inc;
      logic [11:0]     n1;
      logic [7:0]      ratio;
      logic [11:0]     refcnt;
      logic            comp;
      logic [3:0]      acc;
      logic            carry;
      ssp_phase_t      phase;
      ssp_phase_t      rsel;
      logic [11:0]     n1cnt;
      logic [7:0]      ncnt;
   } ssp_dev_st_t;

   ssp_dev_st_t       r;
   ssp_dev_st_t       next_r;
   logic [SYNC_W-1:0] sync_q;
   logic              s_sdata;
   logic              s_sclk;
   logic              s_stb;
   logic              s_ref;
   logic              s_pre;
   logic              sclk_rise;
   logic              stb_rise;
   logic              ref_rise;
   logic              pre_rise;
   ssp_word_a_t       wa;
   ssp_main_freq_long_word_t      wl;
   ssp_word_b_t       wb;
   ssp_word_c_t       wc;
   ssp_word_d_t       wd;
   logic [1:0]        msel;
   logic [11:0]       cnt_nx;
   logic [11:0]       nr_last;
   logic [4:0]        sum;
   logic [3:0]        q;
   logic [7:0]        nx8;

   ssp_sync #(
      .WIDTH (SYNC_W)
   ) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .ce      (ce),
      .d       ({link.sdata, link.sclk, link.strobe, ref_in, pre_pulse}),
      .q       (sync_q)
   );

   assign {s_sdata, s_sclk, s_stb, s_ref, s_pre} = sync_q;
   assign sclk_rise = s_sclk & ~r.sclk_q;
   assign stb_rise  = s_stb & ~r.stb_q;
   assign ref_rise  = s_ref & ~r.ref_q;
   assign pre_rise  = s_pre & ~r.pre_q;

   assign wa = ssp_word_a_t'(r.sr[SR_W-1 -: SHORT_LEN]);
   assign wl = ssp_main_freq_long_word_t'(r.sr);
   assign wb = ssp_word_b_t'(r.sr[SR_W-1 -: SHORT_LEN]);
   assign wc = ssp_word_c_t'(r.sr[SR_W-1 -: SHORT_LEN]);
   assign wd = ssp_word_d_t'(r.sr[SR_W-1 -: SHORT_LEN]);
   // read as second bit then first
   assign msel = {r.work_b.moduli_p2, r.work_b.moduli_p1};

   always_comb begin
      next_r  = r;
      nr_last = r.cfg.ref_div_value - 12'h001;
      // a count left above a newly shortened ratio wraps at once, not after full scale
      cnt_nx  = (r.refcnt >= nr_last) ? 12'h000 : r.refcnt + 12'h001;
      q       = r.cfg.frac_mod_sel ? FRAC_Q8 : FRAC_Q5;
      sum     = {1'b0, r.acc} + {2'h0, r.frac_inc};
      nx8     = r.ncnt + 8'h01;
      if (ce) begin
         next_r.sclk_q = s_sclk;
         next_r.stb_q  = s_stb;
         next_r.ref_q  = s_ref;
         next_r.pre_q  = s_pre;
         // shift in at top, first bit ends lowest
         if (sclk_rise && !s_stb) begin
            next_r.sr = {s_sdata, r.sr[SR_W-1:1]};
         end
         next_r.speedup = r.speedup & s_stb;
         if (stb_rise) begin
            if (!wa.zero) begin
               next_r.work_b = r.hold_b;
               if (r.cfg.long_sel) begin
                  next_r.frac_inc             = wl.base.frac_increment;
                  next_r.n1                   = wl.base.first_ratio_cycles;
                  next_r.ratio                = wl.base.ratio_counts;
                  next_r.work_b.current_scale = wl.current_scale;
                  next_r.hold_b.current_scale = wl.current_scale;
               end else begin
                  next_r.frac_inc = wa.frac_increment;
                  next_r.n1       = wa.first_ratio_cycles;
                  next_r.ratio    = wa.ratio_counts;
               end
               next_r.speedup = 1'b1;
            end else if (wb.prefix == PFX_B) begin
               next_r.hold_b = wb;
            end else if (wc.prefix == PFX_C) begin
               next_r.aux_div = wc.aux_divide;
            end else if (wd.prefix == PFX_D) begin
               next_r.cfg = wd;
            end
         end
         if (pre_rise && !r.cfg.main_off) begin
            if (r.phase == PH_R1) begin
               next_r.carry = 1'b0;
            end
            unique case (r.phase)
               PH_R1: begin
                  next_r.n1cnt = r.n1cnt + 12'h001;
                  if (r.n1cnt + 12'h001 == r.n1) begin
                     next_r.n1cnt = 12'h000;
                     next_r.ncnt  = 8'h00;
                     next_r.phase = PH_R2;
                  end
               end
               PH_R2: begin
                  next_r.ncnt = nx8;
                  // two moduli use the whole byte
                  if (msel == MOD_TWO) begin
                     if (nx8 == r.ratio) begin
                        next_r.phase = PH_R1;
                     end
                  end else if (nx8[3:0] == r.ratio[7:4]) begin
                     next_r.phase = PH_R3;
                  end
               end
               PH_R3: begin
                  next_r.ncnt = nx8;
                  if (nx8[3:0] == r.ratio[3:0]) begin
                     next_r.phase = (msel == MOD_THREE) ? PH_R1 : PH_R4;
                  end
               end
               PH_R4: begin
                  next_r.ncnt = nx8;
                  if (nx8[3:0] == r.work_b.cum_234) begin
                     next_r.phase = PH_R1;
                  end
               end
            endcase
         end
         // two reference periods around divider edge
         if (ref_rise) begin
            next_r.refcnt = cnt_nx;
            next_r.comp   = (cnt_nx == nr_last) || (cnt_nx == 12'h000);
            if (r.refcnt >= nr_last) begin
               if (sum >= {1'b0, q}) begin
                  next_r.acc   = 4'(sum - {1'b0, q});
                  next_r.carry = 1'b1;
               end else begin
                  next_r.acc = sum[3:0];
               end
            end
         end
         // main disable stops pulses and sequencer
         if (r.cfg.main_off) begin
            next_r.refcnt = 12'h000;
            next_r.comp   = 1'b0;
            next_r.phase  = PH_R1;
            next_r.n1cnt  = 12'h000;
            next_r.carry  = 1'b0;
         end
         // a pending carry turns one first-ratio cycle into a second-ratio one
         next_r.rsel = (next_r.phase == PH_R1 && next_r.carry) ? PH_R2 : next_r.phase;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign ratio_sel            = r.rsel;
   assign frac_extra           = r.carry;
   assign comp_pulse           = r.comp;
   assign comp_level           = r.acc[2:0];
   assign comp_shift           = r.speedup ? {1'b0, r.work_b.prop_exp} + 3'h1 : 3'h0;
   assign prop_level           = r.work_b.current_scale;
   assign prop_shift           = comp_shift;
   assign speedup              = r.speedup;
   assign integ_active         = r.speedup;
   assign integ_cancel_pulse   = r.speedup & r.comp;
   assign integ_accel          = r.work_b.integ_accel;
   assign prescaler_moduli_sel = msel;
   assign aux_divide           = r.aux_div;
   assign ref_div_value        = r.cfg.ref_div_value;
   assign main_ref_sel         = r.cfg.main_ref_sel;
   assign aux_ref_sel          = r.cfg.aux_ref_sel;
   assign main_off             = r.cfg.main_off;
   assign aux_off              = r.cfg.aux_off;
   assign frac_mod_sel         = r.cfg.frac_mod_sel;
   assign long_sel             = r.cfg.long_sel;
endmodule

// ### ssp_host.sv
// host end: apb registers and serial word sender for the programming link
`timescale 1ns/1ps
module ssp_host
   import ssp_pkg::*;
#(
   parameter int HALF_CYC = ssp_pkg::HALF_BIT_CYC
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        ce,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   ssp_link_if.host         link
);
   import ssp_pkg::*;

   typedef struct packed {
      ssp_host_st_t st;
      logic [31:0]  word;
      logic         long_w;
      logic [15:0]  hold;
      logic [15:0]  cnt;
      logic [5:0]   bits;
      logic         sclk;
      logic         sdata;
      logic         strobe;
      logic [31:0]  rdata;
      logic         err;
   } ssp_host_reg_t;

   localparam logic [15:0] HALF_LAST = 16'(HALF_CYC - 1);
   localparam logic [5:0]  LAST_S    = 6'(SHORT_LEN - 1);
   localparam logic [5:0]  LAST_L    = 6'(LONG_LEN - 1);

   ssp_host_reg_t r;
   ssp_host_reg_t next_r;
   logic          busy;
   logic          mapped;

   // the device needs a few cycles per half bit to see each edge through its synchroniser
   if (HALF_CYC < 4 || HALF_CYC > 65535) begin : g_chk
      $error("ssp_host: HALF_CYC out of range");
   end

   assign busy   = (r.st != H_IDLE);
   assign mapped = (paddr == REG_CTRL) || (paddr == REG_DATA) || (paddr == REG_STATUS);

   always_comb begin
      next_r = r;
      if (ce) begin
         if (psel && !penable) begin
            next_r.err = !mapped;
            unique case (paddr)
               REG_CTRL:   next_r.rdata = {r.hold, 14'h0000, r.long_w, 1'b0};
               REG_DATA:   next_r.rdata = r.word;
               REG_STATUS: next_r.rdata = {18'h00000, r.bits, 7'h00, busy};
               default:    next_r.rdata = 32'h0000_0000;
            endcase
         end
         unique case (r.st)
            H_IDLE: begin
               next_r.sclk   = 1'b0;
               next_r.strobe = 1'b0;
               if (psel && penable && pwrite && paddr == REG_DATA) begin
                  next_r.word = pwdata;
               end
               if (psel && penable && pwrite && paddr == REG_CTRL) begin
                  next_r.long_w = pwdata[CTRL_LONG];
                  next_r.hold   = pwdata[CTRL_HOLD_LSB +: 16];
                  if (pwdata[CTRL_GO]) begin
                     next_r.sdata = r.word[0];
                     next_r.bits  = 6'h00;
                     next_r.cnt   = 16'h0000;
                     next_r.st    = H_LOW;
                  end
               end
            end
            H_LOW: begin
               next_r.cnt = r.cnt + 16'h0001;
               // bit rate set by half period
               if (r.cnt == HALF_LAST) begin
                  next_r.cnt  = 16'h0000;
                  next_r.sclk = 1'b1;
                  next_r.st   = H_HIGH;
               end
            end
            H_HIGH: begin
               next_r.cnt = r.cnt + 16'h0001;
               if (r.cnt == HALF_LAST) begin
                  next_r.cnt  = 16'h0000;
                  next_r.sclk = 1'b0;
                  // strobe half a period after last edge
                  if (r.bits == (r.long_w ? LAST_L : LAST_S)) begin
                     next_r.strobe = 1'b1;
                     next_r.st     = H_STB;
                  end else begin
                     next_r.bits  = r.bits + 6'h01;
                     next_r.word  = {1'b0, r.word[31:1]};
                     next_r.sdata = r.word[1];
                     next_r.st    = H_LOW;
                  end
               end
            end
            H_STB: begin
               next_r.cnt = r.cnt + 16'h0001;
               // strobe length sets the speed-up time, so software owns it
               if (r.cnt + 16'h0001 >= r.hold) begin
                  next_r.strobe = 1'b0;
                  next_r.cnt    = 16'h0000;
                  next_r.st     = H_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign pready      = 1'b1;
   assign prdata      = r.rdata;
   assign pslverr     = r.err;
   assign link.sclk   = r.sclk;
   assign link.sdata  = r.sdata;
   assign link.strobe = r.strobe;
endmodule

// ### ssp_link_sva.sv
// concurrent checks of the three-wire link and the device pump controls
`timescale 1ns/1ps
module ssp_link_sva (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       sdata,
   input wire logic       sclk,
   input wire logic       strobe,
   input wire logic       speedup,
   input wire logic       integ_active,
   input wire logic       integ_cancel_pulse,
   input wire logic       comp_pulse,
   input wire logic [2:0] comp_level,
   input wire logic [2:0] comp_shift,
   input wire logic [2:0] prop_shift,
   input wire logic       frac_mod_sel,
   input wire logic [1:0] ratio_sel,
   input wire logic       frac_extra
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_high_phase; sclk [*5] ##1 !sclk; endsequence
   sequence s_low_phase; !sclk [*5]; endsequence
   sequence s_data_held; $stable(sdata) [*5]; endsequence

   property p_high_half; $rose(sclk) |-> s_high_phase; endproperty
   a_high_half: assert property (p_high_half) else $error("clock high phase wrong length");
   property p_low_half; $fell(sclk) |-> s_low_phase; endproperty
   a_low_half: assert property (p_low_half) else $error("clock low phase too short");
   property p_data_held; $rose(sclk) |-> s_data_held; endproperty
   a_data_held: assert property (p_data_held) else $error("data moved while clock high");
   property p_strobe_fall; $rose(strobe) |-> $fell(sclk); endproperty
   a_strobe_fall: assert property (p_strobe_fall) else $error("strobe not at clock fall");
   property p_quiet; strobe |-> !sclk; endproperty
   a_quiet: assert property (p_quiet) else $error("clock pulsed under strobe");
   property p_spd_cause; $rose(speedup) |-> strobe && $past(strobe, 3); endproperty
   a_spd_cause: assert property (p_spd_cause) else $error("speedup without strobe");
   property p_spd_shift;
      speedup |-> comp_shift inside {[3'h1:3'h4]} && prop_shift == comp_shift;
   endproperty
   a_spd_shift: assert property (p_spd_shift) else $error("speedup scale wrong");
   property p_norm_shift; !speedup |-> comp_shift == 3'h0 && prop_shift == 3'h0; endproperty
   a_norm_shift: assert property (p_norm_shift) else $error("normal scale not zero");
   property p_integ_pulse; integ_cancel_pulse |-> speedup && comp_pulse; endproperty
   a_integ_pulse: assert property (p_integ_pulse) else $error("integral pulse outside speedup");
   property p_integ_act; integ_active |-> speedup; endproperty
   a_integ_act: assert property (p_integ_act) else $error("integral pump outside speedup");
   property p_level_q; !frac_mod_sel |-> comp_level < 3'h5; endproperty
   a_level_q: assert property (p_level_q) else $error("cancel level above modulus");
   property p_carry_r2; frac_extra |-> ratio_sel != 2'h0; endproperty
   a_carry_r2: assert property (p_carry_r2) else $error("first ratio kept under carry");
endmodule

// ### synth_serial_program_port_test.sv
// self-checking bench: apb host driving the device over the three-wire link
`timescale 1ns/1ps
module synth_serial_program_port_test;
   import ssp_pkg::*;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        ref_in = 1'b0;
   logic        pre_pulse = 1'b0;
   logic [1:0]  tick = 2'h0;
   logic [2:0]  last_shift = 3'h0;
   logic [31:0] prdata, q;
   logic        pready, pslverr, e, speedup, integ_active, integ_cancel_pulse, comp_pulse;
   logic        frac_mod_sel, long_sel, main_off, aux_off, frac_extra;
   logic [2:0]  comp_level, comp_shift, prop_shift;
   logic [7:0]  prop_level, cn;
   logic [3:0]  integ_accel;
   logic [1:0]  prescaler_moduli_sel, main_ref_sel, aux_ref_sel, ratio_sel;
   logic [11:0] aux_divide, ref_div_value;
   logic [1:0]  mods [3] = '{MOD_TWO, MOD_THREE, MOD_FOUR};
   int          n_spd = 0, n_comp = 0;
   int          n0, pw, mismatches = 0, n_tests = 0;
   ssp_word_a_t wa;
   ssp_word_b_t wb;
   ssp_word_d_t wd;

   ssp_link_if ssp_link_if_i ();
   ssp_host ssp_host_i (.clk(clk), .reset_n(reset_n), .ce(1'b1), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(ssp_link_if_i.host));
   ssp_device ssp_device_i (.clk(clk), .reset_n(reset_n), .ce(1'b1), .link(ssp_link_if_i.dev),
      .ref_in(ref_in), .pre_pulse(pre_pulse), .ratio_sel(ratio_sel), .frac_extra(frac_extra),
      .comp_pulse(comp_pulse),
      .comp_level(comp_level), .comp_shift(comp_shift), .prop_level(prop_level),
      .prop_shift(prop_shift), .speedup(speedup), .integ_active(integ_active),
      .integ_cancel_pulse(integ_cancel_pulse), .integ_accel(integ_accel),
      .prescaler_moduli_sel(prescaler_moduli_sel), .aux_divide(aux_divide),
      .ref_div_value(ref_div_value), .main_ref_sel(main_ref_sel), .aux_ref_sel(aux_ref_sel),
      .main_off(main_off), .aux_off(aux_off), .frac_mod_sel(frac_mod_sel), .long_sel(long_sel));
   ssp_link_sva ssp_link_sva_i (.clk(clk), .reset_n(reset_n), .sdata(ssp_link_if_i.sdata),
      .sclk(ssp_link_if_i.sclk), .strobe(ssp_link_if_i.strobe), .speedup(speedup),
      .integ_active(integ_active), .integ_cancel_pulse(integ_cancel_pulse),
      .comp_pulse(comp_pulse), .comp_level(comp_level), .comp_shift(comp_shift),
      .prop_shift(prop_shift), .frac_mod_sel(frac_mod_sel), .ratio_sel(ratio_sel),
      .frac_extra(frac_extra));

   initial begin
      forever #5 clk = ~clk;
   end

   // reference and prescaler run free; speedup activity is tallied for the scenarios
   always @(posedge clk) begin
      tick      <= tick + 2'h1;
      ref_in    <= tick[1];
      pre_pulse <= tick[0];
      if (speedup === 1'b1) begin
         n_spd      <= n_spd + 1;
         last_shift <= comp_shift;
      end
      if (comp_pulse === 1'b1) begin
         n_comp <= n_comp + 1;
      end
   end

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      psel    <= 1'b1;
      penable <= 1'b0;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) begin
         mismatches++;
         tally_and_finish();
      end
      @(posedge clk);
   endtask

   // strobe held 40 cycles so speedup is long enough to be seen
   task automatic send(input logic [31:0] w, input logic lng);
      int k;
      k = 0;
      apb(REG_DATA, 1'b1, w);
      apb(REG_CTRL, 1'b1, {16'h0028, 14'h0000, lng, 1'b1});
      do begin
         apb(REG_STATUS, 1'b0, 32'h0);
         k++;
      end while (q[STAT_BUSY] !== 1'b0 && k < 500);
      if (k >= 500) begin
         mismatches++;
         tally_and_finish();
      end
      repeat (8) @(posedge clk);
   endtask

   // cycles one cancel pulse stays high; a pulse already running is skipped
   task automatic pulse_width(output int w);
      int k;
      k = 0;
      w = 0;
      while (comp_pulse === 1'b1 && k < 200) begin
         @(posedge clk);
         k++;
      end
      while (comp_pulse !== 1'b1 && k < 200) begin
         @(posedge clk);
         k++;
      end
      while (comp_pulse === 1'b1 && k < 200) begin
         @(posedge clk);
         k++;
         w++;
      end
      if (k >= 200) begin
         mismatches++;
         tally_and_finish();
      end
   endtask

   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      tally_and_finish();
   end

   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      apb(REG_STATUS, 1'b0, 32'h0);
      check(q, 32'h0);
      apb(12'h00c, 1'b1, 32'hffffffff);
      check(q, 32'h0);
      check(32'(e), 32'h1);
      wd = '{PFX_D, 12'h00a, 2'h1, 1'b0, 2'h2, 1'b1, 1'b0, 1'b0};
      n0 = n_spd;
      send({8'h00, wd}, 1'b0);
      check(32'({ref_div_value, main_ref_sel, aux_ref_sel}), 32'({12'h00a, 2'h1, 2'h2}));
      check(32'({main_off, aux_off}), 32'h1);
      check(32'({frac_mod_sel, long_sel}), 32'h0);
      pulse_width(pw);
      // two periods of the free reference, four clocks each
      check(pw, 32'h8);
      send({8'h00, PFX_C, 12'h5a3, 8'hff}, 1'b0);
      check(32'(aux_divide), 32'h5a3);
      check(n_spd, n0);
      wa = '{1'b0, 3'h3, 12'h033, 8'h19};
      cn = 8'h00;
      for (int i = 0; i < 3; i++) begin
         wb = '{PFX_B, 4'h7, 8'h90 + 8'(i), 4'h3, 2'h2, mods[i][0], mods[i][1]};
         send({8'h00, wb}, 1'b0);
         check(32'(prop_level), 32'(cn));
         check(32'(prescaler_moduli_sel), i == 0 ? 32'h0 : 32'(mods[i - 1]));
         n0 = n_spd;
         send({8'h00, wa}, 1'b0);
         cn = 8'h90 + 8'(i);
         check(32'({prop_level, integ_accel}), 32'({cn, 4'h3}));
         check(32'(prescaler_moduli_sel), 32'(mods[i]));
         check(32'(n_spd > n0), 32'h1);
         check(32'(last_shift), 32'h3);
      end
      // top nibble 1111 names no word, so nothing may move
      send(32'h00f12345, 1'b0);
      check(32'({aux_divide, prop_level}), 32'({12'h5a3, cn}));
      // main disabled from here: divider and cancel pulses must stay still
      wd = '{PFX_D, 12'h00a, 2'h1, 1'b1, 2'h2, 1'b0, 1'b1, 1'b1};
      send({8'h00, wd}, 1'b0);
      check(32'({main_off, aux_off, frac_mod_sel, long_sel}), 32'hb);
      n0 = n_comp;
      send({wa, 8'h42}, 1'b1);
      check(32'(prop_level), 32'h42);
      check(n_comp, n0);
      tally_and_finish();
   end
endmodule
